// >>> hw/kps_pkg.sv
// package of constants and types for the matrix keypad scanner
package kps_pkg;

  // clock and debounce timing
  localparam int          CLK_KHZ     = 25000;   // pclk rate in kHz
  localparam int          DEBOUNCE_MS = 30;      // debounce wait in ms
  localparam logic [3:0]  MC_DIV      = 4'hC;    // pclk cycles per machine cycle
  localparam int          DEBOUNCE_MC = (CLK_KHZ * DEBOUNCE_MS) / 12; // machine cycles
  localparam logic [2:0]  SETTLE_CYC  = 3'h4;    // pclk cycles after a drive swap

  // line geometry
  localparam int          NLINES      = 8;

  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_PRELOAD = 8'h04;
  localparam logic [7:0]  ADDR_KEY     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
  localparam logic [7:0]  ADDR_INTSTAT = 8'h10;
  localparam logic [7:0]  ADDR_INTMASK = 8'h14;
  localparam logic [7:0]  ADDR_LINES   = 8'h18;

  // field positions
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          STAT_FLAG_BIT  = 0;
  localparam int          STAT_RUN_BIT   = 1;
  localparam int          STAT_BUSY_BIT  = 2;
  localparam int          STAT_SWAP_BIT  = 3;
  localparam int          LINES_RECV_LSB = 0;
  localparam int          LINES_SCAN_LSB = 8;

  // reset values
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic [2:0]  INTMASK_RST  = 3'h0;
  localparam logic [7:0]  KEY_RST      = 8'h00;

  // result of looking for low bits in one line set
  typedef struct packed {
    logic [3:0] zeros;   // number of low bits
    logic [3:0] pos;     // position 1..8 of the highest low bit
  } kps_line_res_t;

  // sticky event bits, same layout in status and mask
  typedef struct packed {
    logic tmr;    // bit 2: delay timer rollover
    logic lock;   // bit 1: event discarded, not exactly one line low (several keys or none)
    logic key;    // bit 0: key address accepted
  } kps_evt_t;

  // key press handler states
  typedef enum logic [2:0] {
    KPS_IDLE,
    KPS_DEBOUNCE,
    KPS_CAPTURE,
    KPS_SWAP,
    KPS_SAMPLE,
    KPS_RESOLVE,
    KPS_DONE
  } kps_handler_t;

endpackage

// >>> hw/kps_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none

module kps_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // one flop pair per bit; first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i]   <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule // kps_sync

`default_nettype wire

// >>> hw/kps_zero_find.sv
// counts the low bits of one line set and locates them
`timescale 1ns/100ps
`default_nettype none

module kps_zero_find (
  input  wire logic [7:0]            lines,
  output kps_pkg::kps_line_res_t     res
);

  // walk bits 0..7, later low bits overwrite the position
  always_comb begin
    res = '0;
    for (int i = 0; i < kps_pkg::NLINES; i++) begin
      if (!lines[i]) begin
        res.zeros = res.zeros + 4'h1;
        res.pos   = 4'(i + 1);
      end
    end
  end

endmodule // kps_zero_find

`default_nettype wire

// >>> hw/kps_scanner.sv
// matrix keypad scanner top with apb register slave
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module kps_scanner #(
  parameter int unsigned DEBOUNCE_MC = kps_pkg::DEBOUNCE_MC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // scan lines
  input  wire logic [7:0]  scan_in,
  output logic      [7:0]  scan_out,
  output logic      [7:0]  scan_oe,
  // receive lines
  input  wire logic [7:0]  recv_in,
  output logic      [7:0]  recv_out,
  output logic      [7:0]  recv_oe,
  // key result
  output logic      [7:0]  key_addr,
  output logic             key_valid,
  output logic             irq
);

  localparam logic [15:0] PRELOAD_RST = 16'(32'h0 - DEBOUNCE_MC);

  kps_pkg::kps_handler_t  state_q;
  kps_pkg::kps_handler_t  state_d;
  kps_pkg::kps_line_res_t recv_res;
  kps_pkg::kps_line_res_t scan_res;
  kps_pkg::kps_evt_t      evt;
  kps_pkg::kps_evt_t      int_stat_q;
  kps_pkg::kps_evt_t      int_mask_q;

  logic [7:0]  recv_s;
  logic [7:0]  scan_s;
  logic [7:0]  recv_hold_q;
  logic [7:0]  scan_hold_q;
  logic [7:0]  key_addr_q;
  logic        key_valid_q;
  logic        irq_q;
  logic        scan_en_q;
  logic [15:0] preload_q;
  logic [15:0] delay_timer_q;
  logic [3:0]  presc_q;
  logic        delay_timer_run_q;
  logic        swap_q;
  logic [2:0]  settle_q;
  logic        kint_q;
  logic        key_irq_flag_q;

  // pin synchronisers
  kps_sync #(.W(8)) u_sync_recv (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (recv_in),
    .sync_out (recv_s)
  );

  kps_sync #(.W(8)) u_sync_scan (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (scan_in),
    .sync_out (scan_s)
  );

  // low-bit search on the captured sets
  kps_zero_find u_find_recv (
    .lines (recv_hold_q),
    .res   (recv_res)
  );

  kps_zero_find u_find_scan (
    .lines (scan_hold_q),
    .res   (scan_res)
  );

  // line drive: rest drives scan low, swap drives receive low
  assign scan_out = 8'h00;
  assign scan_oe  = {8{~swap_q}};
  assign recv_out = 8'h00;
  assign recv_oe  = {8{swap_q}};

  // combined key input and its falling edge
  wire kint      = &recv_s;
  wire kint_fall = kint_q & ~kint;

  // handler decode
  wire in_idle    = (state_q == kps_pkg::KPS_IDLE);
  wire start_svc  = in_idle && scan_en_q && key_irq_flag_q;
  wire svc_end    = (state_q == kps_pkg::KPS_DONE);
  wire recv_one   = (recv_res.zeros == 4'h1);
  wire scan_one   = (scan_res.zeros == 4'h1);
  wire settle_end = (settle_q == 3'h0);

  // machine cycle tick and timer rollover
  wire mc_tick  = delay_timer_run_q && (presc_q == kps_pkg::MC_DIV - 4'h1);
  wire tmr_roll = mc_tick && (delay_timer_q == 16'hFFFF);

  // next handler state; rollover has priority, key waits for idle
  always_comb begin
    state_d = state_q;
    case (state_q)
      kps_pkg::KPS_IDLE: begin
        if (start_svc) begin
          state_d = kps_pkg::KPS_DEBOUNCE;
        end
      end
      kps_pkg::KPS_DEBOUNCE: begin
        if (tmr_roll) begin
          state_d = kps_pkg::KPS_CAPTURE;
        end
      end
      kps_pkg::KPS_CAPTURE: begin
        state_d = kps_pkg::KPS_SWAP;
      end
      kps_pkg::KPS_SWAP: begin
        state_d = recv_one ? kps_pkg::KPS_SAMPLE : kps_pkg::KPS_DONE;
      end
      kps_pkg::KPS_SAMPLE: begin
        if (settle_end) begin
          state_d = kps_pkg::KPS_RESOLVE;
        end
      end
      kps_pkg::KPS_RESOLVE: begin
        state_d = kps_pkg::KPS_DONE;
      end
      kps_pkg::KPS_DONE: begin
        state_d = kps_pkg::KPS_IDLE;
      end
      default: begin
        state_d = kps_pkg::KPS_IDLE;
      end
    endcase
  end

  // events for the sticky status
  assign evt.tmr  = tmr_roll;
  assign evt.lock = ((state_q == kps_pkg::KPS_SWAP) && !recv_one)
                  || ((state_q == kps_pkg::KPS_RESOLVE) && !scan_one);
  assign evt.key  = (state_q == kps_pkg::KPS_RESOLVE) && scan_one;

  // handler state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= kps_pkg::KPS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // key request flag; a new edge wins over either clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kint_q         <= 1'b1;
      key_irq_flag_q <= 1'b0;
    end else begin
      kint_q <= kint;
      if (kint_fall) begin
        key_irq_flag_q <= 1'b1;
      end else if (start_svc || svc_end) begin
        key_irq_flag_q <= 1'b0;
      end
    end
  end

  // debounce timer counting machine cycles of pclk/12
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_timer_q     <= 16'h0000;
      presc_q           <= 4'h0;
      delay_timer_run_q <= 1'b0;
    end else if (start_svc) begin
      delay_timer_q     <= preload_q;
      presc_q           <= 4'h0;
      delay_timer_run_q <= 1'b1;
    end else if (tmr_roll) begin
      delay_timer_q     <= 16'h0000;
      presc_q           <= 4'h0;
      delay_timer_run_q <= 1'b0;
    end else if (delay_timer_run_q) begin
      presc_q       <= mc_tick ? 4'h0 : presc_q + 4'h1;
      delay_timer_q <= mc_tick ? delay_timer_q + 16'h0001 : delay_timer_q;
    end
  end

  // drive swap and settle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_q   <= 1'b0;
      settle_q <= 3'h0;
    end else if ((state_q == kps_pkg::KPS_SWAP) && recv_one) begin
      swap_q   <= 1'b1;
      settle_q <= kps_pkg::SETTLE_CYC;
    end else if (svc_end) begin
      swap_q   <= 1'b0;
    end else if (!settle_end) begin
      settle_q <= settle_q - 3'h1;
    end
  end

  // captured line sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_hold_q <= 8'hFF;
      scan_hold_q <= 8'hFF;
    end else begin
      if (state_q == kps_pkg::KPS_CAPTURE) begin
        recv_hold_q <= recv_s;
      end
      if ((state_q == kps_pkg::KPS_SAMPLE) && settle_end) begin
        scan_hold_q <= scan_s;
      end
    end
  end

  // key address and one-cycle strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_addr_q  <= kps_pkg::KEY_RST;
      key_valid_q <= 1'b0;
    end else begin
      key_valid_q <= evt.key;
      if (evt.key) begin
        key_addr_q <= {scan_res.pos, recv_res.pos};
      end
    end
  end

  assign key_addr  = key_addr_q;
  assign key_valid = key_valid_q;

  // apb decode, zero wait states
  wire acc     = psel && penable;
  wire hit_ctl = (paddr == kps_pkg::ADDR_CTRL);
  wire hit_pre = (paddr == kps_pkg::ADDR_PRELOAD);
  wire hit_key = (paddr == kps_pkg::ADDR_KEY);
  wire hit_sts = (paddr == kps_pkg::ADDR_STATUS);
  wire hit_ist = (paddr == kps_pkg::ADDR_INTSTAT);
  wire hit_msk = (paddr == kps_pkg::ADDR_INTMASK);
  wire hit_lns = (paddr == kps_pkg::ADDR_LINES);
  wire hit     = hit_ctl | hit_pre | hit_key | hit_sts | hit_ist | hit_msk | hit_lns;
  wire wr      = acc && pwrite;

  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  // status word
  wire [31:0] status_w = {28'h0000000,
                          swap_q,
                          !in_idle,
                          delay_timer_run_q,
                          key_irq_flag_q};

  // read mux
  assign prdata = hit_ctl ? {31'h00000000, scan_en_q}
                : hit_pre ? {16'h0000, preload_q}
                : hit_key ? {24'h000000, key_addr_q}
                : hit_sts ? status_w
                : hit_ist ? {29'h00000000, int_stat_q}
                : hit_msk ? {29'h00000000, int_mask_q}
                : hit_lns ? {16'h0000, scan_s, recv_s}
                : 32'h00000000;

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_en_q  <= kps_pkg::CTRL_EN_RST;
      preload_q  <= PRELOAD_RST;
      int_mask_q <= kps_pkg::INTMASK_RST;
    end else if (wr) begin
      if (hit_ctl) scan_en_q  <= pwdata[kps_pkg::CTRL_EN_BIT];
      if (hit_pre) preload_q  <= pwdata[15:0];
      if (hit_msk) int_mask_q <= pwdata[2:0];
    end
  end

  // sticky interrupt status, write one to clear, set wins
  wire [2:0] w1c = (wr && hit_ist) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~w1c) | evt;
      irq_q      <= |(((int_stat_q & ~w1c) | evt) & int_mask_q);
    end
  end

  assign irq = irq_q;

endmodule // kps_scanner

`default_nettype wire

// >>> dv/kps_props.sv
// assertion checker for the keypad scanner ports
`timescale 1ns/100ps
`default_nettype none

module kps_props #(
  parameter int unsigned DEBOUNCE_MC = 4
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] scan_out,
  input wire logic [7:0] scan_oe,
  input wire logic [7:0] recv_in,
  input wire logic [7:0] recv_out,
  input wire logic [7:0] recv_oe,
  input wire logic [7:0] key_addr,
  input wire logic       key_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] lo_q;
  logic [15:0] lo_d;

  // cycles since a receive line first fell at rest
  assign lo_d = (scan_oe != 8'hFF) ? 16'h0 : (lo_q == 16'hFFFF) ? lo_q :
                (lo_q != 16'h0 || !(&recv_in)) ? lo_q + 16'h1 : 16'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_q <= 16'h0;
    else lo_q <= lo_d;
  end

  // the two drive patterns
  sequence s_rest;
    scan_oe == 8'hFF && recv_oe == 8'h00;
  endsequence
  sequence s_swap;
    scan_oe == 8'h00 && recv_oe == 8'hFF;
  endsequence

  a_drive_pair: assert property (s_rest or s_swap)
    else $error("drive pattern neither rest nor swap");
  a_outs_low: assert property (scan_out == 8'h00 && recv_out == 8'h00)
    else $error("driven level not low");
  a_valid_pulse: assert property (key_valid |=> !key_valid)
    else $error("valid longer than one cycle");
  a_addr_range: assert property (key_valid |-> key_addr[7:4] inside {[4'h1:4'h8]}
    && key_addr[3:0] inside {[4'h1:4'h8]}) else $error("key position out of range");
  a_addr_hold: assert property (!key_valid |-> key_addr == $past(key_addr))
    else $error("key address moved without valid");
  a_sample_swapped: assert property (key_valid |-> $past(scan_oe, 3) == 8'h00)
    else $error("key resolved without swapped drive");
  a_restore_soon: assert property (key_valid |-> ##[0:3] s_rest)
    else $error("rest drive not restored");
  a_debounce_wait: assert property ($fell(scan_oe[0]) |-> lo_q >= 16'(DEBOUNCE_MC * 12))
    else $error("lines swapped before debounce end");
endmodule // kps_props

bind kps_scanner kps_props #(.DEBOUNCE_MC(DEBOUNCE_MC)) kps_props_inst (
  .pclk(pclk), .presetn(presetn), .scan_out(scan_out), .scan_oe(scan_oe),
  .recv_in(recv_in), .recv_out(recv_out), .recv_oe(recv_oe),
  .key_addr(key_addr), .key_valid(key_valid));

`default_nettype wire

// >>> dv/kps_matrix.sv
// passive switch matrix seen from the scanner pins
`timescale 1ns/100ps
`default_nettype none

module kps_matrix (
  input  wire logic [63:0] keys,
  input  wire logic [7:0]  scan_oe,
  input  wire logic [7:0]  recv_oe,
  output logic      [7:0]  scan_in,
  output logic      [7:0]  recv_in
);
  // pull-ups where undriven, a closed key ties its two wires
  always_comb begin
    scan_in = ~scan_oe;
    recv_in = ~recv_oe;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 8; j++) begin
        if (keys[i*8+j]) begin
          scan_in[i] = scan_in[i] & ~recv_oe[j];
          recv_in[j] = recv_in[j] & ~scan_oe[i];
        end
      end
    end
  end
endmodule // kps_matrix

`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the keypad scanner
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, key_valid, irq, er;
  logic [7:0]  paddr, scan_in, scan_out, scan_oe, recv_in, recv_out, recv_oe, key_addr, ka;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] keys;
  int          failures, n_checks, nvalid, cyc, n0;
  typedef struct { logic [63:0] k; logic [7:0] a; logic ok; } kps_row_t;
  kps_row_t    rows [6] = '{'{64'h1, 8'h11, 1'b1}, '{64'h8000_0000_0000_0000, 8'h88, 1'b1},
    '{64'h20_0000, 8'h36, 1'b1}, '{64'h2_0000_0000_0000, 8'h72, 1'b1},
    '{64'h808, 8'h72, 1'b0}, '{64'h11_0000, 8'h72, 1'b0}};

  kps_scanner #(.DEBOUNCE_MC(4)) kps_scanner_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_in(scan_in),
    .scan_out(scan_out), .scan_oe(scan_oe), .recv_in(recv_in), .recv_out(recv_out),
    .recv_oe(recv_oe), .key_addr(key_addr), .key_valid(key_valid), .irq(irq));
  kps_matrix kps_matrix_inst (.keys(keys), .scan_oe(scan_oe), .recv_oe(recv_oe),
    .scan_in(scan_in), .recv_in(recv_in));

  // clock and accepted-key counter
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (key_valid === 1'b1) nvalid++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // press, wait bounded for a key, hold, release
  task automatic run_key(input logic [63:0] k, input int hold);
    keys <= k;
    cyc = 0;
    do begin @(posedge pclk); #1; cyc++; end while (key_valid !== 1'b1 && cyc < 400);
    ka = key_addr;
    repeat (hold) @(posedge pclk);
    keys <= '0;
    repeat (30) @(posedge pclk);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, keys} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({scan_oe, recv_oe, key_addr}, 24'hFF0000);
    @(posedge pclk);
    // table of single keys and two-key lockouts
    foreach (rows[n]) begin
      n0 = nvalid;
      run_key(rows[n].k, 40);
      chk(ka, rows[n].a);
      chk(nvalid - n0, rows[n].ok);
      chk(scan_oe, 8'hFF);
      if (rows[n].ok) chk(cyc >= 48 && cyc < 400, 1);
      apb(1'b0, kps_pkg::ADDR_KEY, 0);
      chk(rd, rows[n].a);
      apb(1'b0, kps_pkg::ADDR_INTSTAT, 0);
      chk(rd, {1'b1, !rows[n].ok, rows[n].ok});
      apb(1'b1, kps_pkg::ADDR_INTSTAT, 32'h7);
    end
    // bouncing contact then a long hold
    n0 = nvalid;
    keys <= 64'h400;
    repeat (3) @(posedge pclk);
    keys <= '0;
    repeat (3) @(posedge pclk);
    run_key(64'h400, 150);
    chk(ka, 8'h23);
    chk(nvalid - n0, 1);
    // press released inside the debounce wait
    n0 = nvalid;
    keys <= 64'h1;
    repeat (6) @(posedge pclk);
    keys <= '0;
    repeat (150) @(posedge pclk);
    chk(nvalid - n0, 0);
    apb(1'b0, kps_pkg::ADDR_INTSTAT, 0);
    chk(rd, 32'h7);
    // masking and clearing of the interrupt
    settle();
    chk(irq, 0);
    apb(1'b1, kps_pkg::ADDR_INTMASK, 32'h2);
    settle();
    chk(irq, 1);
    apb(1'b1, kps_pkg::ADDR_INTSTAT, 32'h2);
    settle();
    chk(irq, 0);
    // read-only key register, unmapped address
    apb(1'b1, kps_pkg::ADDR_KEY, 32'hFF);
    apb(1'b0, kps_pkg::ADDR_KEY, 0);
    chk(rd, 8'h23);
    apb(1'b0, 8'h1C, 0);
    chk(er, 1);
    chk(rd, 0);
    // scanning disabled: press only raises the flag, enable starts handling
    n0 = nvalid;
    apb(1'b1, kps_pkg::ADDR_CTRL, 0);
    keys <= 64'h1;
    repeat (10) @(posedge pclk);
    apb(1'b0, kps_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h1);
    apb(1'b0, kps_pkg::ADDR_LINES, 0);
    chk(rd, 32'hFE);
    chk(nvalid - n0, 0);
    apb(1'b1, kps_pkg::ADDR_CTRL, 32'h1);
    run_key(64'h1, 5);
    chk(ka, 8'h11);
    chk(nvalid - n0, 1);
    // longer preload stretches the wait
    apb(1'b1, kps_pkg::ADDR_PRELOAD, 32'hFFF8);
    run_key(64'h1, 5);
    chk(ka, 8'h11);
    chk(cyc >= 96 && cyc < 400, 1);
    wrap_up();
  end
endmodule // tb

`default_nettype wire
